// *** logic/flash_map_cfg.svh ***
`ifndef FLASH_MAP_CFG_SVH
`define FLASH_MAP_CFG_SVH

// Register indices; the bus byte address is four times the index.
`define MISC_IDX        8'h13
`define PORT_DATA_IDX   8'hfc
`define PORT_DIR_IDX    8'hfd
`define PAGE_IDX        8'hff
`define IDX_LSB         2
`define IDX_MSB         9
`define ADDR_HI_LSB     10

// Reset values.
`define MISC_RESET_EXP  8'h0c
`define MISC_RESET_SC   8'h0d
`define DIR_RESET       8'h00
`define DATA_RESET      8'h00
`define PAGE_RESET      3'h0

// Implemented bits of the page port: bit 7, bit 3 and bits 2..0.
`define PORT_MASK       8'h8f
`define CHIP_SEL_BIT    7
`define GPIO_ONLY_BIT   3
`define PIX_TOP_BIT     2

// Quarters of the 64K map, selected by address bits 15..14.
`define Q_FIXED_LO      2'h1
`define Q_WINDOW        2'h2
`define Q_FIXED_HI      2'h3
`define FIXED_LO_PAGE   3'h6
`define FIXED_HI_PAGE   3'h7

// Register-following space: upper five bits match the register block base,
// address bit 10 set.
`define FOLLOW_BIT      10
`define BLOCK_LSB       11

// AHB-Lite encodings.
`define HTRANS_ACT_BIT  1
`define HRESP_OKAY      1'b0

`endif

// *** logic/flash_map_pkg.sv ***
package flash_map_pkg;

   typedef struct packed {
      logic       test_en;
      logic       follow_narrow;
      logic [1:0] follow_stretch;
      logic [1:0] ext_stretch;
      logic       upper_half_only;
      logic       flash_enable;
   } misc_s;

   typedef struct packed {
      logic special;
      logic expanded;
      logic wide;
      logic peripheral;
   } mode_s;

   typedef struct packed {
      logic        flash_hit;
      logic        window_hit;
      logic        follow_hit;
      logic        ext_hit;
      logic        narrow;
      logic [1:0]  stretch;
      logic [3:0]  array_sel;
      logic [16:0] phys_addr;
   } access_s;

   typedef enum logic [0:0] {
      CS_IDLE,
      CS_ACTIVE
   } chip_sel_e;

endpackage : flash_map_pkg

// *** logic/flash_page_window_mapping.sv ***
`include "flash_map_cfg.svh"

module flash_page_window_mapping #(
   parameter int PAGE_BITS = 3
) (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic                    hready,
   input  wire logic [31:0]             hwdata,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire flash_map_pkg::mode_s    mode,
   input  wire logic                    page_port_emul_en,
   input  wire logic [4:0]              reg_base,
   input  wire logic                    other_internal_hit,
   input  wire logic                    cpu_valid,
   input  wire logic [15:0]             cpu_addr,
   input  wire logic                    e_fall,
   input  wire logic                    page_call_we,
   input  wire logic [2:0]              page_call_wdata,
   output logic      [2:0]              page_call_rdata,
   input  wire logic [7:0]              page_port_pin_in,
   output logic      [7:0]              page_port_pin_out,
   output logic      [7:0]              page_port_pin_oe_n,
   output logic                         port_regs_external,
   output flash_map_pkg::access_s       access
);

   if (PAGE_BITS != 3) begin : g_check
      $error("PAGE_BITS must be 3");
   end

   flash_map_pkg::misc_s     misc;
   flash_map_pkg::access_s   next_access;
   flash_map_pkg::chip_sel_e cs_state;
   flash_map_pkg::chip_sel_e next_cs_state;
   logic [2:0]               page_index_bits;
   logic [7:0]               page_port_data;
   logic [7:0]               page_port_direction;
   logic                     misc_written;
   logic                     wr_pend;
   logic                     rd_pend;
   logic [7:0]               acc_idx;
   logic                     acc_ok;
   logic                     take;
   logic                     emul_on;
   logic                     ports_removed;
   logic [1:0]               cs_count;
   logic [1:0]               next_cs_count;

   assign emul_on       = page_port_emul_en;
   assign ports_removed = page_port_emul_en
                          & (mode.expanded | mode.peripheral);
   assign take = hsel & hready & htrans[`HTRANS_ACT_BIT];

   // Is a register index present in the on-chip map.
   function automatic logic mapped(input logic [7:0] idx,
                                   input logic       removed);
      logic hit;
      hit = 1'b0;
      unique case (idx)
         `MISC_IDX:      hit = 1'b1;
         `PAGE_IDX:      hit = 1'b1;
         `PORT_DATA_IDX: hit = !removed;
         `PORT_DIR_IDX:  hit = !removed;
         default:        hit = 1'b0;
      endcase
      return hit;
   endfunction : mapped

   // Read value of a register; input pins read their level.
   function automatic logic [7:0] read_reg(input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         `MISC_IDX:      v = misc;
         `PAGE_IDX:      v = {5'h00, page_index_bits};
         `PORT_DATA_IDX: v = ((page_port_data & page_port_direction)
                             | (page_port_pin_in & ~page_port_direction))
                             & `PORT_MASK;
         `PORT_DIR_IDX:  v = page_port_direction;
         default:        v = 8'h00;
      endcase
      return v;
   endfunction : read_reg

   // Decode of one CPU access against the current mapping.
   function automatic flash_map_pkg::access_s decode(input logic [15:0] a);
      flash_map_pkg::access_s r;
      logic test_win;
      logic block_hit;
      r = '0;
      test_win  = mode.special & misc.test_en;
      block_hit = (a[15:`BLOCK_LSB] == reg_base);
      r.follow_hit = block_hit & a[`FOLLOW_BIT];
      r.window_hit = test_win ? a[15]
                     : (a[15:14] == `Q_WINDOW);
      if (misc.flash_enable) begin
         if (test_win && a[15]) begin
            r.flash_hit = 1'b1;
            r.phys_addr = {page_index_bits[2:1], a[14:0]};
            r.array_sel = misc.upper_half_only ? 4'hf
                          : 4'h1 << page_index_bits[2:1];
         end else if (!test_win) begin
            unique case (a[15:14])
               `Q_WINDOW: begin
                  r.flash_hit = 1'b1;
                  r.phys_addr = {page_index_bits, a[13:0]};
               end
               `Q_FIXED_LO: begin
                  r.flash_hit = !misc.upper_half_only;
                  r.phys_addr = {`FIXED_LO_PAGE, a[13:0]};
               end
               `Q_FIXED_HI: begin
                  r.flash_hit = 1'b1;
                  r.phys_addr = {`FIXED_HI_PAGE, a[13:0]};
               end
               default: r.flash_hit = 1'b0;
            endcase
            r.array_sel = r.flash_hit ? 4'h1 << r.phys_addr[16:15]
                          : 4'h0;
         end
      end
      r.ext_hit = mode.expanded & !r.flash_hit
                  & !(block_hit & !a[`FOLLOW_BIT])
                  & !other_internal_hit;
      r.narrow  = mode.expanded & mode.wide & misc.follow_narrow
                  & r.follow_hit;
      if (mode.expanded && r.follow_hit) begin
         r.stretch = misc.follow_stretch;
      end else if (r.ext_hit) begin
         r.stretch = misc.ext_stretch;
      end
      return r;
   endfunction : decode

   assign next_access = decode(cpu_addr);

   // Bus slave: writes finish with no wait, reads take one wait state.
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         acc_idx   <= 8'h00;
         acc_ok    <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0;
         hresp     <= `HRESP_OKAY;
      end else begin
         hresp <= `HRESP_OKAY;
         if (rd_pend) begin
            rd_pend   <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= acc_ok ? {24'h0, read_reg(acc_idx)} : 32'h0;
         end else if (take) begin
            acc_idx   <= haddr[`IDX_MSB:`IDX_LSB];
            acc_ok    <= (haddr[31:`ADDR_HI_LSB] == '0)
                         && mapped(haddr[`IDX_MSB:`IDX_LSB], ports_removed)
                         && (hsize == 3'h2);
            wr_pend   <= hwrite;
            rd_pend   <= !hwrite;
            hreadyout <= hwrite;
         end else begin
            wr_pend <= 1'b0;
         end
      end
   end

   // Mapping control register.
   always_ff @(posedge clk) begin
      if (reset) begin
         misc         <= mode.expanded ? `MISC_RESET_EXP : `MISC_RESET_SC;
         misc_written <= 1'b0;
      end else begin
         if (wr_pend && acc_ok && acc_idx == `MISC_IDX
             && (mode.special || !misc_written)) begin
            misc         <= hwdata[7:0];
            misc.test_en <= hwdata[7] & mode.special;
            misc_written <= 1'b1;
         end else if (!mode.special) begin
            misc.test_en <= 1'b0;
         end
      end
   end

   // Page index register, bus path and dedicated call and return path.
   always_ff @(posedge clk) begin
      if (reset) begin
         page_index_bits <= `PAGE_RESET;
      end else if (page_call_we) begin
         page_index_bits <= page_call_wdata;
      end else if (wr_pend && acc_ok && acc_idx == `PAGE_IDX) begin
         page_index_bits <= hwdata[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         page_call_rdata <= `PAGE_RESET;
      end else begin
         page_call_rdata <= page_call_we ? page_call_wdata
                            : page_index_bits;
      end
   end

   // Port data and direction registers.
   always_ff @(posedge clk) begin
      if (reset) begin
         page_port_data      <= `DATA_RESET;
         page_port_direction <= `DIR_RESET;
      end else if (wr_pend && acc_ok) begin
         if (acc_idx == `PORT_DATA_IDX) begin
            page_port_data <= hwdata[7:0] & `PORT_MASK;
         end
         if (acc_idx == `PORT_DIR_IDX) begin
            page_port_direction <= hwdata[7:0] & `PORT_MASK;
         end
      end
   end

   // Emulation chip select sequencing over E clock high and stretch.
   always_comb begin
      next_cs_state = cs_state;
      next_cs_count = cs_count;
      unique case (cs_state)
         flash_map_pkg::CS_IDLE: begin
            if (cpu_valid && emul_on && next_access.window_hit) begin
               next_cs_state = flash_map_pkg::CS_ACTIVE;
               next_cs_count = next_access.flash_hit ? 2'h0
                               : next_access.stretch;
            end
         end
         flash_map_pkg::CS_ACTIVE: begin
            if (!emul_on) begin
               next_cs_state = flash_map_pkg::CS_IDLE;
            end else if (e_fall) begin
               if (cs_count == 2'h0) begin
                  next_cs_state = flash_map_pkg::CS_IDLE;
               end else begin
                  next_cs_count = cs_count - 2'h1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cs_state <= flash_map_pkg::CS_IDLE;
         cs_count <= 2'h0;
      end else begin
         cs_state <= next_cs_state;
         cs_count <= next_cs_count;
      end
   end

   localparam logic [7:0] PORT_MASK_V = `PORT_MASK;

   // Pin drivers; output enable is active low.
   for (genvar i = 0; i < 8; i++) begin : g_pin
      if (!PORT_MASK_V[i]) begin : g_absent
         always_ff @(posedge clk) begin
            page_port_pin_out[i]  <= 1'b0;
            page_port_pin_oe_n[i] <= 1'b1;
         end
      end else if (i == `CHIP_SEL_BIT) begin : g_chip_sel
         always_ff @(posedge clk) begin
            if (reset) begin
               page_port_pin_out[i]  <= 1'b0;
               page_port_pin_oe_n[i] <= 1'b1;
            end else if (emul_on) begin
               page_port_pin_out[i]  <= (next_cs_state
                                        != flash_map_pkg::CS_ACTIVE);
               page_port_pin_oe_n[i] <= 1'b0;
            end else begin
               page_port_pin_out[i]  <= page_port_data[i];
               page_port_pin_oe_n[i] <= !page_port_direction[i];
            end
         end
      end else if (i == `GPIO_ONLY_BIT) begin : g_gpio
         always_ff @(posedge clk) begin
            if (reset) begin
               page_port_pin_out[i]  <= 1'b0;
               page_port_pin_oe_n[i] <= 1'b1;
            end else begin
               page_port_pin_out[i]  <= page_port_data[i];
               page_port_pin_oe_n[i] <= !page_port_direction[i];
            end
         end
      end else begin : g_index
         always_ff @(posedge clk) begin
            if (reset) begin
               page_port_pin_out[i]  <= 1'b0;
               page_port_pin_oe_n[i] <= 1'b1;
            end else if (emul_on) begin
               page_port_pin_out[i]  <= page_index_bits[i];
               page_port_pin_oe_n[i] <= 1'b0;
            end else begin
               page_port_pin_out[i]  <= page_port_data[i];
               page_port_pin_oe_n[i] <= !page_port_direction[i];
            end
         end
      end
   end

   // Registered decode of the last CPU access.
   always_ff @(posedge clk) begin
      if (reset) begin
         access             <= '0;
         port_regs_external <= 1'b0;
      end else begin
         port_regs_external <= ports_removed;
         if (cpu_valid) begin
            access <= next_access;
         end
      end
   end

endmodule : flash_page_window_mapping

// *** test/flash_map_assertions.sv ***
module flash_map_checker (
   input wire logic                    clk,
   input wire logic                    reset,
   input wire logic                    hsel,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic                    hready,
   input wire logic                    hreadyout,
   input wire flash_map_pkg::mode_s    mode,
   input wire logic                    page_port_emul_en,
   input wire logic [4:0]              reg_base,
   input wire logic                    cpu_valid,
   input wire logic [15:0]             cpu_addr,
   input wire logic                    e_fall,
   input wire logic [2:0]              page_call_rdata,
   input wire logic [7:0]              page_port_pin_out,
   input wire logic                    port_regs_external,
   input wire flash_map_pkg::access_s  access
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_read_wait: assert property (
      hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_ready: assert property (
      hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled");
   a_cs_window: assert property (
      cpu_valid && page_port_emul_en && mode.expanded
      && cpu_addr[15:14] == 2'h2 |=> access.window_hit
      && (!page_port_emul_en || !page_port_pin_out[7]))
      else $error("chip select missed window");
   a_cs_release: assert property (
      !$past(reset, 2) && $rose(page_port_pin_out[7])
      && $past(page_port_emul_en) && $past(page_port_emul_en, 2)
      |-> $past(e_fall))
      else $error("chip select released off E edge");
   a_pix_show: assert property (
      !$past(reset) && $past(page_port_emul_en) && $stable(page_call_rdata)
      |-> page_port_pin_out[2:0] == page_call_rdata)
      else $error("index pins differ from page index");
   a_regs_out: assert property (
      !$past(reset) |-> port_regs_external == $past(page_port_emul_en
      && (mode.expanded || mode.peripheral)))
      else $error("port register removal wrong");
   a_follow_hit: assert property (
      cpu_valid && mode.expanded |=> access.follow_hit
      == ($past(cpu_addr[15:10]) == {$past(reg_base), 1'b1}))
      else $error("follow space decode wrong");
   a_narrow_wide: assert property (
      cpu_valid && !(mode.expanded && mode.wide) |=> !access.narrow)
      else $error("narrow path outside wide expanded");
   a_no_stretch: assert property (
      cpu_valid && !mode.expanded |=> access.stretch == 2'h0)
      else $error("stretch outside expanded mode");

   c_emul: cover property (cpu_valid && page_port_emul_en);
   c_release: cover property ($rose(page_port_pin_out[7]));
   c_follow: cover property (access.follow_hit);
endmodule : flash_map_checker

bind flash_page_window_mapping flash_map_checker u_flash_map_checker (
   .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .mode(mode),
   .page_port_emul_en(page_port_emul_en), .reg_base(reg_base),
   .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .e_fall(e_fall),
   .page_call_rdata(page_call_rdata),
   .page_port_pin_out(page_port_pin_out),
   .port_regs_external(port_regs_external), .access(access));

// *** test/flash_page_window_mapping_tb_top.sv ***
`include "flash_map_cfg.svh"
module flash_page_window_mapping_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    clk = 0, reset = 1, hsel = 0, hwrite = 0;
   logic                    cpu_valid = 0, e_fall = 0, emul = 0;
   logic                    page_call_we = 0, hreadyout, hresp, regs_ext;
   logic [31:0]             haddr = 0, hwdata = 0, hrdata;
   logic [1:0]              htrans = 0, ec = 0;
   logic [2:0]              hsize = 3'h2, page_call_wdata = 0, prd;
   logic [15:0]             cpu_addr = 0;
   logic [4:0]              reg_base = 0;
   logic [7:0]              ext = 8'hff, pin_in, pin_out, oe_n;
   flash_map_pkg::mode_s    mode = 4'he;
   flash_map_pkg::access_s  acc;
   int                      mismatches = 0, n_tests = 0;

   always #4 clk = ~clk;
   always @(posedge clk) begin
      ec <= ec + 2'h1;
      e_fall <= (ec == 2'h3);
   end

   flash_page_window_mapping u_flash_page_window_mapping (
      .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .mode(mode), .page_port_emul_en(emul),
      .reg_base(reg_base), .other_internal_hit(1'b0),
      .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .e_fall(e_fall),
      .page_call_we(page_call_we), .page_call_wdata(page_call_wdata),
      .page_call_rdata(prd), .page_port_pin_in(pin_in),
      .page_port_pin_out(pin_out), .page_port_pin_oe_n(oe_n),
      .port_regs_external(regs_ext), .access(acc));
   pin_pod u_pin_pod (.pin_out(pin_out), .oe_n(oe_n), .ext(ext),
      .pin_in(pin_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask : wr

   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] x;
      bus(1'b0, idx, 8'h00, x);
      chk(x, {24'h0, e});
   endtask : rdc

   task automatic cpu(input logic [15:0] a);
      @(posedge clk iff e_fall);
      cpu_valid <= 1'b1;
      cpu_addr <= a;
      @(posedge clk);
      cpu_valid <= 1'b0;
      #1;
   endtask : cpu

   task automatic cs_len(input int exp);
      int n;
      n = 0;
      chk(32'(pin_out[7]), 32'h0);
      while (pin_out[7] === 1'b0 && n < 8) begin
         @(posedge clk);
         n = n + 32'(e_fall);
      end
      chk(32'(n), 32'(exp));
   endtask : cs_len

   task automatic do_reset(input flash_map_pkg::mode_s m);
      @(posedge clk);
      reset <= 1'b1;
      mode <= m;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
   endtask : do_reset

   task automatic t_regs;
      rdc(`MISC_IDX, `MISC_RESET_EXP);
      rdc(`PORT_DIR_IDX, 8'h00);
      rdc(`PAGE_IDX, 8'h00);
      rdc(`PORT_DATA_IDX, 8'h8f);
      wr(`PAGE_IDX, 8'hff);
      rdc(`PAGE_IDX, 8'h07);
      wr(8'h20, 8'h55);
      rdc(8'h20, 8'h00);
      @(posedge clk);
      page_call_we <= 1'b1;
      page_call_wdata <= 3'h5;
      @(posedge clk);
      page_call_we <= 1'b0;
      rdc(`PAGE_IDX, 8'h05);
      chk(32'(prd), 32'h5);
      $display("register test done");
   endtask : t_regs

   task automatic t_map;
      wr(`MISC_IDX, 8'h01);
      cpu(16'h8123);
      chk(32'(acc.phys_addr), 32'h14123);
      chk(32'(acc.flash_hit), 32'h1);
      cpu(16'h4010);
      chk(32'(acc.phys_addr), 32'h18010);
      wr(`MISC_IDX, 8'h03);
      cpu(16'h4010);
      chk(32'(acc.flash_hit), 32'h0);
      wr(`MISC_IDX, 8'h00);
      cpu(16'h8123);
      chk(32'(acc.flash_hit), 32'h0);
      wr(`MISC_IDX, 8'h81);
      wr(`PAGE_IDX, 8'h03);
      cpu(16'hf000);
      chk(32'(acc.array_sel), 32'h2);
      chk(32'(acc.phys_addr), 32'h0f000);
      wr(`MISC_IDX, 8'h83);
      cpu(16'h9000);
      chk(32'(acc.array_sel), 32'hf);
      wr(`MISC_IDX, 8'h81);
      $display("mapping test done");
   endtask : t_map

   task automatic t_emul;
      wr(`MISC_IDX, 8'h01);
      wr(`PORT_DIR_IDX, 8'h8f);
      wr(`PORT_DATA_IDX, 8'h8a);
      cpu(16'h8000);
      chk(32'(pin_out & 8'h8f), 32'h8a);
      chk(32'(oe_n), 32'h70);
      @(posedge clk);
      mode <= 4'h8;
      emul <= 1'b1;
      wr(`PAGE_IDX, 8'h06);
      wr(`PORT_DATA_IDX, 8'h00);
      wr(`PORT_DIR_IDX, 8'h87);
      @(posedge clk);
      #1;
      chk(32'(pin_out & 8'h8f), 32'h86);
      chk(32'(oe_n), 32'h78);
      cpu(16'h8000);
      cs_len(1);
      @(posedge clk);
      mode <= 4'h9;
      rdc(`PORT_DATA_IDX, 8'h00);
      chk(32'(regs_ext), 32'h1);
      @(posedge clk);
      mode <= 4'hc;
      rdc(`PORT_DATA_IDX, 8'h00);
      chk(32'(regs_ext), 32'h1);
      wr(`MISC_IDX, 8'h08);
      cpu(16'h8000);
      cs_len(3);
      $display("emulation test done");
   endtask : t_emul

   task automatic t_once;
      do_reset(4'h0);
      rdc(`MISC_IDX, `MISC_RESET_SC);
      do_reset(4'h6);
      wr(`MISC_IDX, 8'he5);
      rdc(`MISC_IDX, 8'h65);
      wr(`MISC_IDX, 8'h00);
      rdc(`MISC_IDX, 8'h65);
      cpu(16'h0500);
      chk(32'({acc.follow_hit, acc.narrow, acc.stretch}), 32'he);
      @(posedge clk);
      reg_base <= 5'h04;
      cpu(16'h2400);
      chk(32'(acc.follow_hit), 32'h1);
      cpu(16'h0500);
      chk(32'({acc.ext_hit, acc.stretch}), 32'h5);
      $display("write once test done");
   endtask : t_once

   initial begin
      do_reset(4'he);
      t_regs;
      t_map;
      t_emul;
      t_once;
      close_out;
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out;
   end
endmodule : flash_page_window_mapping_tb_top

// *** test/pin_pod.sv ***
module pin_pod (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] oe_n,
   input  wire logic [7:0] ext,
   output logic      [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released pins show the pod level, which idles high through pull-ups.
   assign pin_in = (pin_out & ~oe_n) | (ext & oe_n);
endmodule : pin_pod
